// ---- src/sea_pkg.sv ----
// Purpose: shared constants and types for the switch event alert enables
// Assumes: registers are reached over the device's internal register port
// Notes: bit layout of the status register mirrors the enable register
package sea_pkg;
  // register offsets
  localparam logic [7:0] SEA_OFS_EDGE_SEL = 8'h23;
  localparam logic [7:0] SEA_OFS_ALERT_EN = 8'h24;
  localparam logic [7:0] SEA_OFS_STATUS = 8'h02;
  // widths and reset values
  localparam int SEA_DATA_W = 24;
  localparam int SEA_NUM_SW = 7;
  localparam int SEA_GRP3_CNT = 4;
  localparam int SEA_EDGE_W = 14;
  localparam logic [13:0] SEA_EDGE_SEL_RST = 14'h0000;
  localparam logic [7:0] SEA_ALERT_EN_RST = 8'h00;
  // edge-select encodings
  localparam logic [1:0] SEA_EDGE_NONE = 2'h0;
  localparam logic [1:0] SEA_EDGE_RISE = 2'h1;
  localparam logic [1:0] SEA_EDGE_FALL = 2'h2;
  localparam logic [1:0] SEA_EDGE_BOTH = 2'h3;
  // field positions in enable and status registers
  localparam int SEA_BIT_LINK_FAIL = 0;
  localparam int SEA_BIT_PARITY = 1;
  localparam int SEA_BIT_SWITCH = 2;
  localparam int SEA_BIT_TSD = 3;
  localparam int SEA_BIT_TW = 4;
  localparam int SEA_BIT_OV = 5;
  localparam int SEA_BIT_UV = 6;
  localparam int SEA_BIT_CRC = 7;

  // one-cycle event pulses from the rest of the device
  typedef struct packed {
    logic checksum_done;
    logic supply_low;
    logic supply_high;
    logic thermal_warning;
    logic thermal_shutdown;
    logic parity_error;
    logic link_fail;
  } sea_src_s;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [23:0] wdata;
  } sea_req_s;

  // all state of the block
  typedef struct packed {
    logic [6:0] sw_meta;
    logic [6:0] sw_sync;
    logic [6:0] sw_prev;
    logic [13:0] edge_sel;
    logic [7:0] alert_en;
    logic [7:0] status;
    logic [23:0] rdata;
    logic rvalid;
    logic alert_n;
  } sea_state_s;

  // true when the configured direction matches the observed transition
  function automatic logic sea_edge_hit(input logic [1:0] sel, input logic prev,
                                        input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    case (sel)
      SEA_EDGE_RISE: sea_edge_hit = rise;
      SEA_EDGE_FALL: sea_edge_hit = fall;
      SEA_EDGE_BOTH: sea_edge_hit = rise | fall;
      default: sea_edge_hit = 1'b0;
    endcase
  endfunction
endpackage

// ---- src/sea_alert_enables.sv ----
// Purpose: switch edge events, event status and the active-low alert pin
// Assumes: comparator results are asynchronous; event sources are same-clock pulses
// Notes: status reads clear all pending events; a new event in that cycle survives
//
// Behaviour
// R1 - field value 1 flags rising, 2 flags falling, 3 flags both crossings
// R2 - field value 0 produces no switch event for that input
// R3 - input 12 at bits 1-0, each next input next pair, 18 at 13-12
// R4 - inputs 12 to 15 judged against the shared group3 threshold
// R5 - inputs 16 to 18 judged against a separate group4 threshold
// R6 - enable bit 7 lets checksum completion assert the alert
// R7 - enable bit 6 lets undervoltage assert the alert
// R8 - enable bit 5 lets supply-high fault assert the alert
// R9 - enable bit 4 lets thermal warning assert the alert
// R10 - enable bit 3 lets thermal shutdown assert the alert
// R11 - enable bit 2 lets switch-state change assert the alert
// R12 - enable bit 1 lets parity failure assert the alert
// R13 - enable bit 0 lets serial link failure assert the alert
// R14 - enable bits 23-8 read-only zero; only bits 7-0 writable
// R15 - enable register at 24h, all registers reset to zero, alert pin resets high
// R16 - switch event is the OR of selected per-input edge events
// R17 - reading event status clears the pending switch event
// R18 - alert low while any enabled source has a pending event
// R19 - edges found by comparing current and previous sampled comparator result
`timescale 1ns/1ps
module sea_alert_enables
  import sea_pkg::*;
(
  input wire logic clk_sys_in, // 50 MHz system clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic [3:0] grp3_comp_in, // comparators of inputs 12-15, group3 threshold
  input wire logic [2:0] grp4_comp_in, // comparators of inputs 16-18, group4 threshold
  input wire sea_src_s src_in, // other event pulses
  input wire sea_req_s req_in, // register access request
  output logic [23:0] rdata_out, // read data
  output logic rvalid_out, // read data valid pulse
  output logic [7:0] status_out, // pending events
  output logic alert_n_out // alert pin, active low
);

  sea_state_s st_reg;
  sea_state_s st_next;
  logic [6:0] sw_hit;
  logic switch_change_event;
  logic [7:0] raw_evt;
  logic status_rd;

  // per-input edge detection against the previous sample
  always_comb begin
    for (int i = 0; i < SEA_NUM_SW; i++) begin
      sw_hit[i] = sea_edge_hit(st_reg.edge_sel[2*i +: 2], st_reg.sw_prev[i],
                               st_reg.sw_sync[i]); // [R1] [R2] [R3] [R19]
    end
  end

  assign switch_change_event = |sw_hit; // [R16]
  assign status_rd = req_in.rd && (req_in.addr == SEA_OFS_STATUS);

  // raw events, placed at the bit of their enable
  always_comb begin
    raw_evt = 8'h00;
    raw_evt[SEA_BIT_CRC] = src_in.checksum_done;
    raw_evt[SEA_BIT_UV] = src_in.supply_low;
    raw_evt[SEA_BIT_OV] = src_in.supply_high;
    raw_evt[SEA_BIT_TW] = src_in.thermal_warning;
    raw_evt[SEA_BIT_TSD] = src_in.thermal_shutdown;
    raw_evt[SEA_BIT_SWITCH] = switch_change_event;
    raw_evt[SEA_BIT_PARITY] = src_in.parity_error;
    raw_evt[SEA_BIT_LINK_FAIL] = src_in.link_fail;
  end

  // next-state logic
  always_comb begin
    st_next = st_reg;
    // two flops before any logic sees the comparators
    st_next.sw_meta = {grp4_comp_in, grp3_comp_in}; // [R4] [R5]
    st_next.sw_sync = st_reg.sw_meta;
    st_next.sw_prev = st_reg.sw_sync; // [R19]
    // register writes; upper bits of each word are dropped
    if (req_in.wr && (req_in.addr == SEA_OFS_EDGE_SEL)) begin
      st_next.edge_sel = req_in.wdata[SEA_EDGE_W-1:0]; // [R3]
    end
    if (req_in.wr && (req_in.addr == SEA_OFS_ALERT_EN)) begin
      st_next.alert_en = req_in.wdata[7:0]; // [R14] [R15]
    end
    // read clears, but a new event in the same cycle sets again
    st_next.status = (status_rd ? 8'h00 : st_reg.status) | raw_evt; // [R17]
    // read data one cycle after the request
    st_next.rvalid = req_in.rd;
    st_next.rdata = 24'h000000;
    if (req_in.rd) begin
      case (req_in.addr)
        SEA_OFS_EDGE_SEL: st_next.rdata = {10'h000, st_reg.edge_sel};
        SEA_OFS_ALERT_EN: st_next.rdata = {16'h0000, st_reg.alert_en}; // [R14]
        SEA_OFS_STATUS: st_next.rdata = {16'h0000, st_reg.status};
        default: st_next.rdata = 24'h000000;
      endcase
    end
    // enables only gate the pin, status keeps recording regardless
    st_next.alert_n = ~|(st_next.status & st_next.alert_en); // [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R18]
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.edge_sel <= SEA_EDGE_SEL_RST; // [R15]
      st_reg.alert_en <= SEA_ALERT_EN_RST; // [R15]
      st_reg.alert_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_out = st_reg.rdata;
  assign rvalid_out = st_reg.rvalid;
  assign status_out = st_reg.status;
  assign alert_n_out = st_reg.alert_n;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence s_status_read;
    req_in.rd && req_in.addr == SEA_OFS_STATUS;
  endsequence

  // pin level that the registered status and enables call for
  sequence s_pin_follows;
    alert_n_out == ~|(status_out & st_reg.alert_en);
  endsequence

  // switch event recorded in the status register one cycle later
  sequence s_rise_seen;
    ##1 status_out[SEA_BIT_SWITCH];
  endsequence

  a_alert_pin_level: assert property (1'b1 |-> ##0 alert_n_out == ~|(status_out & st_reg.alert_en)) // [R18]
    else $error("alert pin disagrees with pending enabled events");
  a_switch_disable: assert property (st_reg.alert_en[SEA_BIT_SWITCH] == 1'b0 && $rose(switch_change_event)
                                      |-> ##1 status_out[SEA_BIT_SWITCH]) // [R11]
    else $error("switch event not recorded");
  a_zero_select_quiet: assert property (st_reg.edge_sel == 14'h0000 |-> !switch_change_event) // [R2]
    else $error("switch event with all selects zero");
  a_rise_detect: assert property (st_reg.edge_sel[1:0] == SEA_EDGE_RISE && !st_reg.sw_prev[0]
                                   && st_reg.sw_sync[0] |-> ##1 status_out[SEA_BIT_SWITCH]) // [R1]
    else $error("rising edge on input 12 missed");
  a_fall_only: assert property (st_reg.edge_sel == {7{SEA_EDGE_FALL}} && (st_reg.sw_prev & ~st_reg.sw_sync) == 7'h00
                                 |-> !switch_change_event) // [R1]
    else $error("falling select fired without a fall");
  a_read_clears: assert property (s_status_read and !switch_change_event && raw_evt == 8'h00
                                   |-> ##1 status_out == 8'h00 ##0 s_pin_follows) // [R17]
    else $error("status read did not clear events");
  a_reserved_zero: assert property (req_in.rd && req_in.addr == SEA_OFS_ALERT_EN
                                     |-> ##1 rvalid_out && rdata_out[23:8] == 16'h0000) // [R14]
    else $error("reserved enable bits read nonzero");
  a_crc_enable: assert property (st_reg.alert_en == 8'h80 && src_in.checksum_done && !status_rd
                                  && !req_in.wr
                                  |-> ##1 !alert_n_out [*1] ##1 1'b1) // [R6]
    else $error("checksum completion did not assert alert");
  a_uv_masked: assert property (st_reg.alert_en == 8'h40 && status_out == 8'h00
                                 && raw_evt[SEA_BIT_UV] == 1'b0 && !(req_in.wr) |-> ##1 alert_n_out) // [R7]
    else $error("alert asserted without undervoltage");
  a_enable_write: assert property (req_in.wr && req_in.addr == SEA_OFS_ALERT_EN
                                    |-> ##1 st_reg.alert_en == $past(req_in.wdata[7:0])) // [R15]
    else $error("enable register write lost");
  // each enabled source must pull the pin low the cycle after its pulse
  a_uv_enable: assert property (st_reg.alert_en[SEA_BIT_UV] && src_in.supply_low && !req_in.wr
                                 |-> ##1 !alert_n_out) // [R7]
    else $error("undervoltage did not assert alert");
  a_ov_enable: assert property (st_reg.alert_en[SEA_BIT_OV] && src_in.supply_high && !req_in.wr
                                 |-> ##1 !alert_n_out) // [R8]
    else $error("supply-high fault did not assert alert");
  a_tw_enable: assert property (st_reg.alert_en[SEA_BIT_TW] && src_in.thermal_warning
                                 && !req_in.wr |-> ##1 !alert_n_out) // [R9]
    else $error("thermal warning did not assert alert");
  a_tsd_enable: assert property (st_reg.alert_en[SEA_BIT_TSD] && src_in.thermal_shutdown
                                  && !req_in.wr |-> ##1 !alert_n_out) // [R10]
    else $error("thermal shutdown did not assert alert");
  a_switch_enable: assert property (st_reg.alert_en[SEA_BIT_SWITCH] && switch_change_event
                                     && !req_in.wr |-> ##1 !alert_n_out) // [R11]
    else $error("switch change did not assert alert");
  a_parity_enable: assert property (st_reg.alert_en[SEA_BIT_PARITY] && src_in.parity_error
                                     && !req_in.wr |-> ##1 !alert_n_out) // [R12]
    else $error("parity failure did not assert alert");
  a_link_enable: assert property (st_reg.alert_en[SEA_BIT_LINK_FAIL] && src_in.link_fail
                                   && !req_in.wr |-> ##1 !alert_n_out) // [R13]
    else $error("link failure did not assert alert");
  // pending events stay until the host reads them
  a_status_sticky: assert property (!status_rd && status_out[SEA_BIT_CRC]
                                     |-> ##1 status_out[SEA_BIT_CRC]) // [R17]
    else $error("pending event lost without a read");
  a_status_rdata: assert property (status_rd |-> ##1 rvalid_out
                                    && rdata_out[7:0] == $past(status_out)) // [R17]
    else $error("status read returned wrong value");
  // direction checks on a field of each threshold group
  a_fall_detect: assert property (st_reg.edge_sel[1:0] == SEA_EDGE_FALL && st_reg.sw_prev[0]
                                   && !st_reg.sw_sync[0] |-> ##1 status_out[SEA_BIT_SWITCH]) // [R1]
    else $error("falling edge on input 12 missed");
  a_group3_both: assert property (st_reg.edge_sel[7:6] == SEA_EDGE_BOTH
                                   && st_reg.sw_prev[3] != st_reg.sw_sync[3] |-> s_rise_seen) // [R4]
    else $error("edge on input 15 missed");
  a_group4_rise: assert property (st_reg.edge_sel[9:8] == SEA_EDGE_RISE && !st_reg.sw_prev[4]
                                   && st_reg.sw_sync[4] |-> s_rise_seen) // [R5]
    else $error("rising edge on input 16 missed");
  a_field_off: assert property (st_reg.edge_sel[1:0] == SEA_EDGE_NONE |-> !sw_hit[0]) // [R2]
    else $error("input 12 flagged with its field off");
  a_edge_sel_write: assert property (req_in.wr && req_in.addr == SEA_OFS_EDGE_SEL
                                      |-> ##1 st_reg.edge_sel == $past(req_in.wdata[13:0])) // [R3]
    else $error("edge-select register write lost");
  a_any_hit: assert property (sw_hit != 7'h00 |-> switch_change_event) // [R16]
    else $error("selected edge not aggregated");

endmodule // sea_alert_enables

// ---- verification/sea_host_model.sv ----
// Purpose: host side of the register port of the alert block
// Assumes: requests change at the falling edge and hold over one rising edge
// Notes: reading event status is how the host clears pending events
`timescale 1ns/1ps
module sea_host_model
  import sea_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic [23:0] rdata_in, // read data from device
  input wire logic rvalid_in, // read data valid pulse
  output sea_req_s req_out // request to device
);
  initial req_out = '0;
  // one write; released data is inverted so a stale value never looks valid
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    @(negedge clk_sys_in);
    req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_in);
    req_out.wr = 1'b0;
    req_out.wdata = ~d;
  endtask
  // read with a bounded wait for the answer; status reads clear events
  task automatic rd_reg(input logic [7:0] a, output logic [23:0] d, output bit ok);
    ok = 1'b0;
    d = '0;
    @(negedge clk_sys_in);
    req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: req_out.wdata};
    @(negedge clk_sys_in);
    req_out.rd = 1'b0;
    // answer stands for the cycle after the request edge
    ok = (rvalid_in === 1'b1);
    d = rdata_in;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk_sys_in);
      ok = (rvalid_in === 1'b1);
      d = rdata_in;
    end
  endtask
endmodule // sea_host_model

// ---- verification/sea_alert_enables_bench.sv ----
// Purpose: self-checking bench for the switch event alert block
// Assumes: host model drives the register port, bench drives events
// Notes: expected status and alert come from a plain model in the bench
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module sea_alert_enables_bench import sea_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [6:0] comp_v = '0;
  sea_src_s src_v = '0;
  sea_req_s req_v;
  logic [23:0] rdata_v;
  logic rvalid_v;
  logic [7:0] status_v;
  logic alert_n_v;
  logic [23:0] rd_v;
  bit ok;
  int error_cnt = 0;
  int n_tests = 0;
  int exp_stat;
  int en;
  // 50 MHz clock
  initial forever #10 clk_sys_in = ~clk_sys_in;
  sea_alert_enables u_sea_alert_enables (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .grp3_comp_in(comp_v[3:0]), .grp4_comp_in(comp_v[6:4]), .src_in(src_v),
    .req_in(req_v), .rdata_out(rdata_v), .rvalid_out(rvalid_v),
    .status_out(status_v), .alert_n_out(alert_n_v));
  sea_host_model u_sea_host_model (.clk_sys_in(clk_sys_in), .rdata_in(rdata_v),
    .rvalid_in(rvalid_v), .req_out(req_v));
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // read through the host; a missing answer ends the run
  task automatic rd_chk(input logic [7:0] a, input logic [23:0] e);
    u_sea_host_model.rd_reg(a, rd_v, ok);
    if (!ok) begin
      error_cnt++;
      wrap_up();
    end
    `CHK(rd_v, e)
  endtask
  // reference edge detector, own code so a shared slip cannot hide
  function automatic logic hit(input int s, input logic p, input logic c);
    return ((s & 1) != 0 && !p && c) || ((s & 2) != 0 && p && !c);
  endfunction
  // main sequence
  initial begin
    void'($urandom(32'hf2f4f8c4));
    repeat (5) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    `CHK(alert_n_v, 1'b1)
    rd_chk(SEA_OFS_ALERT_EN, 24'h000000);
    rd_chk(SEA_OFS_EDGE_SEL, 24'h000000);
    u_sea_host_model.wr_reg(SEA_OFS_ALERT_EN, 24'hFFFFFF);
    rd_chk(SEA_OFS_ALERT_EN, 24'h0000FF);
    u_sea_host_model.wr_reg(SEA_OFS_EDGE_SEL, 24'hFFFFFF);
    rd_chk(SEA_OFS_EDGE_SEL, 24'h003FFF);
    rd_chk(8'h7F, 24'h000000);
    $display("test registers done");
    // each source pulse but the switch change against a random enable; reserved bits random too
    for (int i = 0; i < 8; i++) begin
      if (i == SEA_BIT_SWITCH) continue;
      en = $urandom & 32'h000000FF;
      u_sea_host_model.wr_reg(SEA_OFS_ALERT_EN, {16'($urandom), 8'(en)});
      @(negedge clk_sys_in);
      src_v[(i > 2) ? i - 1 : i] = 1'b1;
      @(negedge clk_sys_in);
      src_v = '0;
      @(negedge clk_sys_in);
      `CHK(alert_n_v, ~en[i])
      `CHK(status_v, 8'(1 << i))
      rd_chk(SEA_OFS_STATUS, 24'(1 << i));
      `CHK(alert_n_v, 1'b1)
    end
    $display("test sources done");
    // every field value on every input, rising then falling
    u_sea_host_model.wr_reg(SEA_OFS_ALERT_EN, 24'h000004);
    for (int k = 0; k < SEA_NUM_SW; k++) begin
      for (int s = 0; s < 4; s++) begin
        u_sea_host_model.wr_reg(SEA_OFS_EDGE_SEL, 24'(s << (2 * k)));
        for (int v = 1; v >= 0; v--) begin
          @(negedge clk_sys_in);
          comp_v[k] = v[0];
          repeat (5) @(negedge clk_sys_in);
          exp_stat = hit(s, !v[0], v[0]) ? 4 : 0;
          `CHK(alert_n_v, exp_stat == 0)
          rd_chk(SEA_OFS_STATUS, 24'(exp_stat));
        end
      end
    end
    $display("test edges done");
    wrap_up();
  end
endmodule // sea_alert_enables_bench
